//--- src/crs_map.vh
// Purpose: constants for the card run/transfer host controller
// Assumes: included by bare name
// Notes: device status bits, command codes, buffer codes, own registers
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
// Device status bits
`define CRS_ST_INIT_PRE 32'h0000_0001
`define CRS_ST_TRIG 32'h0000_0002
`define CRS_ST_DONE 32'h0000_0004
`define CRS_ST_SEG_PRE 32'h0000_0008
// Device command codes
`define CRS_CMD_START 32'h0000_0004
`define CRS_CMD_TRIG_EN 32'h0000_0008
// Device register offsets
`define CRS_DEV_STATUS 16'h006E
`define CRS_DEV_CMD 16'h0064
`define CRS_DEV_MEMSIZE 16'h0070
`define CRS_DEV_MEMTEST 16'h0074
// Buffer type and direction codes
`define CRS_BUF_DATA 16'h03E8
`define CRS_BUF_SLOW 16'h07D0
`define CRS_BUF_TSTAMP 16'h0BB8
`define CRS_DIR_H2C 2'h0
`define CRS_DIR_C2H 2'h1
`define CRS_DIR_C2A 2'h2
`define CRS_DIR_A2C 2'h3
// Notify size limits
`define CRS_PAGE_MASK 32'h0000_0FFF
`define CRS_MIN_SIDE_NOTIFY 32'h0000_0800
// Own register offsets
`define CRS_R_CTRL 4'h0
`define CRS_R_BTYPE 4'h1
`define CRS_R_NOTIFY 4'h2
`define CRS_R_OFFS 4'h3
`define CRS_R_LEN 4'h4
`define CRS_R_MEMSIZE 4'h5
`define CRS_R_STATUS 4'h6
`define CRS_R_DEVST 4'h7
// Control register bits
`define CRS_C_START 0
`define CRS_C_TRIGEN 1
`define CRS_C_GEN 2
`define CRS_C_MEMTEST 3
`define CRS_C_DEFINE 4
`define CRS_C_INVAL 5
`define CRS_C_XSTART 6
`endif

//--- src/crs_cmd_port.v
// Purpose: one-word write/read sequencer toward the device registers
// Assumes: device answers reads while its pin strobe stands
// Notes: busy while a request is outstanding
`include "crs_map.vh"
module crs_cmd_port
(
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire req_i,
    input wire req_wr_i,
    input wire [15:0] req_addr_i,
    input wire [31:0] req_data_i,
    output reg busy_o,
    output reg done_o,
    output reg [31:0] rd_data_o,
    output reg dev_wr_o,
    output reg dev_rd_o,
    output reg [15:0] dev_addr_o,
    output reg [31:0] dev_wdata_o,
    input wire [31:0] dev_rdata_i
);
    reg [1:0] rd_wait_r;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rd_data_o <= 32'h0000_0000;
            dev_wr_o <= 1'b0;
            dev_rd_o <= 1'b0;
            dev_addr_o <= 16'h0000;
            dev_wdata_o <= 32'h0000_0000;
            rd_wait_r <= 2'b00;
        end
        else if (ce_i)
        begin
            dev_wr_o <= 1'b0;
            dev_rd_o <= 1'b0;
            done_o <= 1'b0;
            // Pin strobe lags ours by one cycle
            if (rd_wait_r[1])
            begin
                rd_wait_r <= 2'b00;
                rd_data_o <= dev_rdata_i;
                done_o <= 1'b1;
                busy_o <= 1'b0;
            end
            else if (rd_wait_r[0])
                rd_wait_r <= 2'b10;
            else if (busy_o && dev_wr_o)
            begin
                done_o <= 1'b1;
                busy_o <= 1'b0;
            end
            else if (req_i && !busy_o)
            begin
                busy_o <= 1'b1;
                dev_addr_o <= req_addr_i;
                dev_wdata_o <= req_data_i;
                dev_wr_o <= req_wr_i;
                dev_rd_o <= !req_wr_i;
                rd_wait_r <= {1'b0, !req_wr_i};
            end
        end
    end
endmodule

//--- src/crs_buf_check.v
// Purpose: validates a transfer buffer definition before it is sent
// Assumes: inputs stable while checked
// Notes: purely combinational
`include "crs_map.vh"
module crs_buf_check
(
    input wire [15:0] btype_i,
    input wire [1:0] dir_i,
    input wire [31:0] notify_i,
    input wire gen_mode_i,
    input wire memtest_i,
    output wire ok_o
);
    wire type_ok;
    wire dir_ok;
    wire frac_ok;
    wire notify_ok;
    assign type_ok = (btype_i == `CRS_BUF_DATA) ||
        (btype_i == `CRS_BUF_SLOW) || (btype_i == `CRS_BUF_TSTAMP);
    // Direction must fit the mode
    assign dir_ok = memtest_i ||
        !((dir_i == `CRS_DIR_H2C) && !gen_mode_i) &&
        !((dir_i == `CRS_DIR_C2H) && gen_mode_i);
    // Fractions 16 bytes to 2k, one bit only
    assign frac_ok = (notify_i == 32'h0000_0010) ||
        (notify_i == 32'h0000_0020) || (notify_i == 32'h0000_0040) ||
        (notify_i == 32'h0000_0080) || (notify_i == 32'h0000_0100) ||
        (notify_i == 32'h0000_0200) || (notify_i == 32'h0000_0400) ||
        (notify_i == 32'h0000_0800);
    assign notify_ok = ((notify_i & `CRS_PAGE_MASK) == 32'h0000_0000) ||
        ((btype_i == `CRS_BUF_DATA) ? frac_ok :
        (frac_ok && notify_i >= `CRS_MIN_SIDE_NOTIFY));
    assign ok_o = type_ok && dir_ok && notify_ok;
endmodule

//--- src/crs_host_ctrl.v
// Purpose: host-side controller for card run and transfer setup
// Assumes: device reached by one-word register port, answers during strobe
// Notes: software orders through own register file, polling device status
//
// Decided for this implementation: the strobed register port.
`include "crs_map.vh"
// Functional notes
// - Triggers checked only once detection enabled
// - Buffer type codes 1000, 2000, 3000
// - Direction codes 0 to 3
// - Direction must match mode unless memtest
// - Notify multiple of 4k or fraction
// - Side buffers notify at least 2k
// - Memory size programmed before transfers
// - Hardware buffer size set before definitions
// - Transfer only on defined buffer, once
// - Invalidate buffer before discarding it
// - Definition carries type, direction, notify, offsets
// - Start command code 4h
// - Trigger enable code 8h, else disabled
module crs_host_ctrl
(
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg dev_wr_o,
    output reg dev_rd_o,
    output reg [15:0] dev_addr_o,
    output reg [31:0] dev_wdata_o,
    input wire [31:0] dev_rdata_i,
    input wire dev_notify_i,
    output reg buf_valid_o,
    output reg [31:0] buf_offs_o,
    output reg [31:0] buf_len_o,
    output reg xfer_go_o
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_MEM = 3'h1;
    localparam S_TEST = 3'h2;
    localparam S_CMD = 3'h3;
    localparam S_POLL = 3'h4;
    localparam S_WAIT = 3'h5;

    reg [2:0] state_r;
    reg [31:0] ctrl_r;
    reg [15:0] btype_r;
    reg [1:0] dir_r;
    reg [31:0] notify_r;
    reg [31:0] offs_r;
    reg [31:0] len_r;
    reg [31:0] memsize_r;
    reg [31:0] dev_st_r;
    reg memsize_set_r;
    reg mem_sent_r;
    reg defined_r;
    reg busy_run_r;
    reg def_err_r;
    reg dir_err_r;
    reg [31:0] notify_cnt_r;
    reg [31:0] xfer_done_r;
    reg req_r;
    reg req_wr_r;
    reg [15:0] req_addr_r;
    reg [31:0] req_data_r;
    wire busy_w;
    wire done_w;
    wire [31:0] rd_w;
    wire wr_w;
    wire rd_s_w;
    wire [15:0] a_w;
    wire [31:0] d_w;
    wire buf_ok_w;

    crs_cmd_port u_port
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .req_i(req_r),
        .req_wr_i(req_wr_r),
        .req_addr_i(req_addr_r),
        .req_data_i(req_data_r),
        .busy_o(busy_w),
        .done_o(done_w),
        .rd_data_o(rd_w),
        .dev_wr_o(wr_w),
        .dev_rd_o(rd_s_w),
        .dev_addr_o(a_w),
        .dev_wdata_o(d_w),
        .dev_rdata_i(dev_rdata_i)
    );
    crs_buf_check u_chk
    (
        .btype_i(btype_r),
        .dir_i(dir_r),
        .notify_i(notify_r),
        .gen_mode_i(ctrl_r[`CRS_C_GEN]),
        .memtest_i(ctrl_r[`CRS_C_MEMTEST]),
        .ok_o(buf_ok_w)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] run_cmd;
        input [31:0] ctrl;
        input [31:0] prev;
        begin
            run_cmd = ((prev & `CRS_CMD_START) != 32'h0000_0000) ?
                `CRS_CMD_TRIG_EN : `CRS_CMD_START |
                (ctrl[`CRS_C_TRIGEN] ? `CRS_CMD_TRIG_EN : 32'h0000_0000);
        end
    endfunction
    function [31:0] own_status;
        input [2:0] st;
        input defd;
        input run;
        input derr;
        input rerr;
        begin
            own_status = {24'h00_0000, st, rerr, derr, run, defd,
                memsize_set_r};
        end
    endfunction

    // ------------------------------------------------------------
    // Device signals out
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dev_wr_o <= 1'b0;
            dev_rd_o <= 1'b0;
            dev_addr_o <= 16'h0000;
            dev_wdata_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            dev_wr_o <= wr_w;
            dev_rd_o <= rd_s_w;
            dev_addr_o <= a_w;
            dev_wdata_o <= d_w;
        end
    end

    // ------------------------------------------------------------
    // Register file and run sequencer
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= S_IDLE;
            ctrl_r <= 32'h0000_0000;
            btype_r <= `CRS_BUF_DATA;
            dir_r <= `CRS_DIR_C2H;
            notify_r <= 32'h0000_0000;
            offs_r <= 32'h0000_0000;
            len_r <= 32'h0000_0000;
            memsize_r <= 32'h0000_0000;
            dev_st_r <= 32'h0000_0000;
            memsize_set_r <= 1'b0;
            mem_sent_r <= 1'b0;
            defined_r <= 1'b0;
            busy_run_r <= 1'b0;
            def_err_r <= 1'b0;
            dir_err_r <= 1'b0;
            notify_cnt_r <= 32'h0000_0000;
            xfer_done_r <= 32'h0000_0000;
            req_r <= 1'b0;
            req_wr_r <= 1'b0;
            req_addr_r <= 16'h0000;
            req_data_r <= 32'h0000_0000;
            rdata_o <= 32'h0000_0000;
            buf_valid_o <= 1'b0;
            buf_offs_o <= 32'h0000_0000;
            buf_len_o <= 32'h0000_0000;
            xfer_go_o <= 1'b0;
        end
        else if (ce_i)
        begin
            req_r <= 1'b0;
            xfer_go_o <= 1'b0;
            ctrl_r[`CRS_C_START] <= 1'b0;
            ctrl_r[`CRS_C_DEFINE] <= 1'b0;
            ctrl_r[`CRS_C_INVAL] <= 1'b0;
            ctrl_r[`CRS_C_XSTART] <= 1'b0;
            // Reads have no side effects
            if (rd_i)
            begin
                case (addr_i)
                    `CRS_R_CTRL: rdata_o <= ctrl_r;
                    `CRS_R_BTYPE: rdata_o <= {14'h0000, dir_r, btype_r};
                    `CRS_R_NOTIFY: rdata_o <= notify_r;
                    `CRS_R_OFFS: rdata_o <= offs_r;
                    `CRS_R_LEN: rdata_o <= len_r;
                    `CRS_R_MEMSIZE: rdata_o <= memsize_r;
                    `CRS_R_STATUS: rdata_o <= own_status(state_r,
                        defined_r, busy_run_r, def_err_r, dir_err_r);
                    `CRS_R_DEVST: rdata_o <= dev_st_r;
                    default: rdata_o <= 32'h0000_0000;
                endcase
            end
            if (wr_i)
            begin
                case (addr_i)
                    `CRS_R_CTRL: ctrl_r <= wdata_i;
                    `CRS_R_BTYPE:
                    begin
                        btype_r <= wdata_i[15:0];
                        dir_r <= wdata_i[17:16];
                    end
                    `CRS_R_NOTIFY: notify_r <= wdata_i;
                    `CRS_R_OFFS: offs_r <= wdata_i;
                    `CRS_R_LEN: len_r <= wdata_i;
                    `CRS_R_MEMSIZE:
                    begin
                        memsize_r <= wdata_i;
                        memsize_set_r <= 1'b1;
                        mem_sent_r <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // Buffer definition, checked and latched
            if (ctrl_r[`CRS_C_DEFINE])
            begin
                if (buf_ok_w && mem_sent_r && !buf_valid_o)
                begin
                    defined_r <= 1'b1;
                    buf_valid_o <= 1'b1;
                    buf_offs_o <= offs_r;
                    buf_len_o <= len_r;
                    notify_cnt_r <= 32'h0000_0000;
                    xfer_done_r <= 32'h0000_0000;
                end
                else
                begin
                    def_err_r <= 1'b1;
                    dir_err_r <= !buf_ok_w;
                end
            end
            // Explicit invalidation before discard
            if (ctrl_r[`CRS_C_INVAL])
            begin
                defined_r <= 1'b0;
                buf_valid_o <= 1'b0;
            end
            // Transfer starts only on a defined buffer
            if (ctrl_r[`CRS_C_XSTART] && defined_r && mem_sent_r)
                xfer_go_o <= 1'b1;
            // Count notify chunks; buffer used once
            if (dev_notify_i && buf_valid_o)
            begin
                xfer_done_r <= xfer_done_r + ((notify_r == 32'h0000_0000) ?
                    buf_len_o : notify_r);
                if (notify_r == 32'h0000_0000 ||
                    xfer_done_r + notify_r >= buf_len_o)
                begin
                    buf_valid_o <= 1'b0;
                    defined_r <= 1'b0;
                end
            end
            case (state_r)
                S_IDLE:
                begin
                    if (!mem_sent_r && memsize_set_r)
                        state_r <= S_MEM;
                    else if (ctrl_r[`CRS_C_START])
                    begin
                        state_r <= S_TEST;
                        busy_run_r <= 1'b1;
                    end
                end
                S_MEM:
                begin
                    if (!busy_w && !req_r && !done_w)
                    begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CRS_DEV_MEMSIZE;
                        req_data_r <= memsize_r;
                    end
                    if (done_w)
                    begin
                        mem_sent_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_TEST:
                begin
                    if (!busy_w && !req_r && !done_w)
                    begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CRS_DEV_MEMTEST;
                        req_data_r <= {31'h0000_0000,
                            ctrl_r[`CRS_C_MEMTEST]};
                    end
                    if (done_w)
                        state_r <= S_CMD;
                end
                S_CMD:
                begin
                    if (!busy_w && !req_r && !done_w)
                    begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b1;
                        req_addr_r <= `CRS_DEV_CMD;
                        req_data_r <= run_cmd(ctrl_r, req_data_r);
                    end
                    if (done_w)
                        state_r <= S_POLL;
                end
                S_POLL:
                begin
                    if (!busy_w && !req_r && !done_w)
                    begin
                        req_r <= 1'b1;
                        req_wr_r <= 1'b0;
                        req_addr_r <= `CRS_DEV_STATUS;
                    end
                    if (done_w)
                    begin
                        dev_st_r <= rd_w;
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    // Run ends on complete flag in either mode
                    if ((dev_st_r & `CRS_ST_DONE) != 32'h0000_0000)
                    begin
                        busy_run_r <= 1'b0;
                        state_r <= S_IDLE;
                    end
                    else if (ctrl_r[`CRS_C_TRIGEN] &&
                        (req_data_r & `CRS_CMD_TRIG_EN) == 32'h0000_0000 &&
                        (dev_st_r & `CRS_ST_TRIG) == 32'h0000_0000 &&
                        (ctrl_r[`CRS_C_GEN] ||
                        (dev_st_r & `CRS_ST_INIT_PRE) != 32'h0000_0000))
                        state_r <= S_CMD;
                    else
                        state_r <= S_POLL;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

//--- test/crs_host_ctrl_assertions.sv
// Purpose: port checker for the host controller
// Assumes: one clock, async active-low reset
// Notes: bound onto every controller instance
`include "crs_map.vh"
module crs_host_ctrl_chk
(
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire dev_wr_o,
    input wire dev_rd_o,
    input wire [15:0] dev_addr_o,
    input wire [31:0] dev_wdata_o,
    input wire [31:0] dev_rdata_i,
    input wire dev_notify_i,
    input wire buf_valid_o,
    input wire [31:0] buf_offs_o,
    input wire [31:0] buf_len_o,
    input wire xfer_go_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg ms_r;
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            ms_r <= 1'b0;
        else if (dev_wr_o && dev_addr_o == `CRS_DEV_MEMSIZE)
            ms_r <= 1'b1;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    cmd_code_ok_a: assert property (
        dev_wr_o && dev_addr_o == `CRS_DEV_CMD |->
        dev_wdata_o != 0 && (dev_wdata_o & ~32'h0000_000C) == 0)
        else $error("bad device command word");
    go_needs_buf_a: assert property (xfer_go_o |-> buf_valid_o)
        else $error("transfer start without buffer");
    go_single_a: assert property (xfer_go_o |=> !xfer_go_o)
        else $error("transfer start not one cycle");
    buf_hold_a: assert property (
        buf_valid_o && $past(buf_valid_o) |->
        $stable(buf_offs_o) && $stable(buf_len_o))
        else $error("buffer fields moved while defined");
    inval_clear_a: assert property (
        wr_i && ce_i && addr_i == `CRS_R_CTRL && wdata_i[`CRS_C_INVAL]
        |-> ##[1:3] !buf_valid_o)
        else $error("invalidate did not clear buffer");
    ms_before_go_a: assert property (xfer_go_o |-> ms_r)
        else $error("transfer before memory size");
    ms_before_def_a: assert property ($rose(buf_valid_o) |-> ms_r)
        else $error("buffer defined before memory size");
    poll_status_a: assert property (
        dev_rd_o |-> dev_addr_o == `CRS_DEV_STATUS)
        else $error("device read not of status");
    cover property (xfer_go_o);
    cover property (dev_wr_o && dev_wdata_o == 32'h0000_000C);
    cover property ($fell(buf_valid_o));
    cover property (dev_wr_o && dev_wdata_o == 32'h0000_0008);
endmodule
bind crs_host_ctrl crs_host_ctrl_chk u_host_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dev_wr_o(dev_wr_o),
    .dev_rd_o(dev_rd_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .dev_rdata_i(dev_rdata_i),
    .dev_notify_i(dev_notify_i), .buf_valid_o(buf_valid_o),
    .buf_offs_o(buf_offs_o), .buf_len_o(buf_len_o),
    .xfer_go_o(xfer_go_o));

//--- test/crs_dev_model.sv
// Purpose: behavioural card model for the host controller
// Assumes: status read answered in the strobe cycle
// Notes: single-shot run, short counts
`include "crs_map.vh"
module crs_dev_model
#(
    parameter PRE = 20,
    parameter POST = 30,
    parameter NDLY = 20
)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire gen_i,
    input wire dev_wr_i,
    input wire dev_rd_i,
    input wire [15:0] dev_addr_i,
    input wire [31:0] dev_wdata_i,
    input wire xfer_go_i,
    output wire [31:0] dev_rdata_o,
    output reg notify_o,
    output reg [31:0] memsize_o,
    output reg [31:0] cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg run_r, ten_r, ph_r;
    reg [31:0] st_r;
    reg [7:0] cnt_r, ncnt_r;
    // Outside a read the bus shows scrambled data
    assign dev_rdata_o = !dev_rd_i ? ~st_r :
        (dev_addr_i == `CRS_DEV_STATUS) ? st_r : 32'h0;
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            {run_r, ten_r, ph_r, notify_o} <= 4'h0;
            st_r <= 32'h0;
            cnt_r <= 8'h0;
            ncnt_r <= 8'h0;
            memsize_o <= 32'h0;
            cmd_o <= 32'h0;
        end
        else
        begin
            notify_o <= (ncnt_r == 8'h1);
            ncnt_r <= xfer_go_i ? NDLY : ncnt_r - (ncnt_r != 8'h0);
            cnt_r <= cnt_r + 8'h1;
            if (dev_wr_i && dev_addr_i == `CRS_DEV_MEMSIZE)
                memsize_o <= dev_wdata_i;
            if (dev_wr_i && dev_addr_i == `CRS_DEV_CMD)
            begin
                cmd_o <= dev_wdata_i;
                ten_r <= dev_wdata_i[3] | (ten_r & !dev_wdata_i[2]);
                if (dev_wdata_i[2])
                begin
                    {run_r, ph_r} <= 2'h2;
                    cnt_r <= 8'h0;
                    st_r <= 32'h0;
                end
            end
            else if (run_r && !ph_r)
            begin
                if (!gen_i && cnt_r == PRE)
                    st_r <= st_r | 32'h9;
                if (ten_r && (gen_i || st_r[0]))
                begin
                    st_r <= st_r | 32'h2;
                    ph_r <= 1'b1;
                    cnt_r <= 8'h0;
                end
            end
            else if (run_r && cnt_r == POST)
            begin
                st_r <= st_r | 32'h4;
                run_r <= 1'b0;
            end
        end
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the host controller
// Assumes: card model answers status polls
// Notes: short card counts
`include "crs_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg ce_i = 1'b1;
    reg gen_m = 1'b0;
    reg [3:0] addr_i = 4'h0;
    reg [31:0] wdata_i = 32'h0;
    reg [31:0] v;
    wire [31:0] rdata_o, dev_wdata_o, dev_rdata_i, buf_offs_o, buf_len_o;
    wire [31:0] msz, cmd;
    wire [15:0] dev_addr_o;
    wire dev_wr_o, dev_rd_o, dev_notify_i, buf_valid_o, xfer_go_o;
    integer err_count = 0;
    integer cmp_count = 0;
    integer go_n = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (xfer_go_o === 1'b1)
            go_n <= go_n + 1;
    crs_host_ctrl u_crs_host_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .dev_wr_o(dev_wr_o),
        .dev_rd_o(dev_rd_o), .dev_addr_o(dev_addr_o),
        .dev_wdata_o(dev_wdata_o), .dev_rdata_i(dev_rdata_i),
        .dev_notify_i(dev_notify_i), .buf_valid_o(buf_valid_o),
        .buf_offs_o(buf_offs_o), .buf_len_o(buf_len_o),
        .xfer_go_o(xfer_go_o));
    crs_dev_model u_crs_dev_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .gen_i(gen_m), .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o),
        .dev_addr_i(dev_addr_o), .dev_wdata_i(dev_wdata_o),
        .xfer_go_i(xfer_go_o), .dev_rdata_o(dev_rdata_i),
        .notify_o(dev_notify_i), .memsize_o(msz), .cmd_o(cmd));
    task chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] d);
    begin
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    end
    endtask
    task rd(input [3:0] a);
    begin
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    end
    endtask
    task try_def(input [15:0] t, input [1:0] d, input [31:0] n,
        input [31:0] m, input e);
    begin
        wr(`CRS_R_BTYPE, {14'h0, d, t});
        wr(`CRS_R_NOTIFY, n);
        wr(`CRS_R_CTRL, m | 32'h10);
        repeat (4) @(posedge clk_i);
        chk(buf_valid_o, e);
        wr(`CRS_R_CTRL, m | 32'h20);
        repeat (4) @(posedge clk_i);
        chk(buf_valid_o, 0);
    end
    endtask
    task poll(input [31:0] e);
        integer i;
    begin
        v = 32'h0;
        repeat (16) @(posedge clk_i);
        for (i = 0; i < 100 && v[2] !== 1'b1; i = i + 1)
            rd(`CRS_R_DEVST);
        chk(v, e);
    end
    endtask
    task finish_test;
    begin
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    initial
    begin
        #100000;
        err_count = err_count + 1;
        finish_test;
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`CRS_R_STATUS);
        chk(v, 0);
        rd(4'hC);
        chk(v, 0);
        try_def(`CRS_BUF_DATA, 1, 0, 0, 0);
        wr(`CRS_R_MEMSIZE, 32'h0010_0000);
        repeat (8) @(posedge clk_i);
        chk(msz, 32'h0010_0000);
        try_def(`CRS_BUF_DATA, 1, 0, 0, 1);
        try_def(`CRS_BUF_SLOW, 1, 32'h800, 0, 1);
        try_def(`CRS_BUF_TSTAMP, 1, 32'h1000, 0, 1);
        try_def(16'h04D2, 1, 0, 0, 0);
        try_def(`CRS_BUF_DATA, 0, 0, 0, 0);
        try_def(`CRS_BUF_DATA, 2, 0, 0, 1);
        try_def(`CRS_BUF_DATA, 3, 0, 0, 1);
        try_def(`CRS_BUF_DATA, 0, 0, 4, 1);
        try_def(`CRS_BUF_DATA, 1, 0, 4, 0);
        try_def(`CRS_BUF_DATA, 0, 0, 8, 1);
        try_def(`CRS_BUF_DATA, 1, 32'h10, 0, 1);
        try_def(`CRS_BUF_DATA, 1, 32'h30, 0, 0);
        try_def(`CRS_BUF_SLOW, 1, 32'h400, 0, 0);
        wr(`CRS_R_OFFS, 32'h0000_0100);
        wr(`CRS_R_LEN, 32'h0000_4000);
        wr(`CRS_R_BTYPE, {16'h0001, `CRS_BUF_DATA});
        wr(`CRS_R_NOTIFY, 0);
        wr(`CRS_R_CTRL, 32'h10);
        repeat (4) @(posedge clk_i);
        chk(buf_offs_o, 32'h0000_0100);
        chk(buf_len_o, 32'h0000_4000);
        wr(`CRS_R_CTRL, 32'h40);
        repeat (40) @(posedge clk_i);
        chk(go_n, 1);
        chk(buf_valid_o, 0);
        wr(`CRS_R_CTRL, 32'h40);
        repeat (8) @(posedge clk_i);
        chk(go_n, 1);
        wr(`CRS_R_CTRL, 32'h3);
        poll(32'hF);
        chk(cmd, 32'hC);
        rd(`CRS_R_STATUS);
        chk(v & 32'h4, 0);
        wr(`CRS_R_CTRL, 32'h1);
        repeat (150) @(posedge clk_i);
        rd(`CRS_R_DEVST);
        chk(v, 32'h9);
        chk(cmd, 32'h4);
        wr(`CRS_R_CTRL, 32'h2);
        poll(32'hF);
        chk(cmd, 32'h8);
        ce_i <= 1'b0;
        wr(`CRS_R_OFFS, 32'h0000_0055);
        ce_i <= 1'b1;
        rd(`CRS_R_OFFS);
        chk(v, 32'h0000_0100);
        gen_m <= 1'b1;
        wr(`CRS_R_CTRL, 32'h7);
        poll(32'h6);
        finish_test;
    end
endmodule
